// File: rtl/pdm_ctrl.sv
// power-down mode controller with clock gating and an AXI4-Lite register slave
//
// Behaviour
// - seven modes: high-speed active plus six reduced-power modes.
// - medium-speed active runs CPU and peripherals at osc/8, /16, /32 or /64.
// - subactive runs CPU and peripherals from subclock divided by 2, 4 or 8.
// - sleep stops CPU; peripherals on full or divided system clock.
// - subsleep and watch halt CPU; peripherals on divided or plain subclock.
// - standby stops CPU and every peripheral clock.
// - per-module standby gates single peripheral clocks in every mode.
// - wake from standby, or from watch with low-speed clear, restarts oscillator, waits for its start.
// - after clock start, hold CPU and peripherals for programmed wait, then active.
// - the wait select field sits in bits 6 to 4 of control one.
// - sleep request: standby bit 0 goes to sleep/subsleep, 1 to standby/watch.
// - low-speed bit picks system clock or subclock when watch mode ends.
// - 13-bit prescaler clears and stops while system clock is off.
// - divider code 00 selects osc/8.
`timescale 1ns/1ps
`default_nettype none
module pdm_ctrl #(
   parameter int NUM_MOD = 16
) (
   input  wire logic                          core_clk,        // 250 MHz core clock
   input  wire logic                          rst_n,           // sync reset, active low
   input  wire logic                          osc_tick,        // main oscillator tick
   input  wire logic                          sub_tick,        // watch subclock tick
   input  wire logic                          osc_started,     // oscillator has started
   input  wire logic                          sleep_req,       // sleep instruction pulse
   input  wire logic                          wake_irq,        // interrupt request level
   input  wire logic [pdm_pkg::AXI_AW-1:0]    s_axi_awaddr,    // write address
   input  wire logic                          s_axi_awvalid,   // write address valid
   output var  logic                          s_axi_awready,   // write address ready
   input  wire logic [31:0]                   s_axi_wdata,     // write data
   input  wire logic [3:0]                    s_axi_wstrb,     // write strobes
   input  wire logic                          s_axi_wvalid,    // write data valid
   output var  logic                          s_axi_wready,    // write data ready
   output var  logic [1:0]                    s_axi_bresp,     // write response
   output var  logic                          s_axi_bvalid,    // write response valid
   input  wire logic                          s_axi_bready,    // write response ready
   input  wire logic [pdm_pkg::AXI_AW-1:0]    s_axi_araddr,    // read address
   input  wire logic                          s_axi_arvalid,   // read address valid
   output var  logic                          s_axi_arready,   // read address ready
   output var  logic [31:0]                   s_axi_rdata,     // read data
   output var  logic [1:0]                    s_axi_rresp,     // read response
   output var  logic                          s_axi_rvalid,    // read data valid
   input  wire logic                          s_axi_rready,    // read data ready
   output var  logic                          cpu_clk_en_q,    // CPU clock enable
   output var  logic [NUM_MOD-1:0]            periph_clk_en_q, // per-module clock enable
   output var  logic                          osc_run_q,       // main oscillator on
   output var  logic [pdm_pkg::PRESC_W-1:0]   prescaler_q,     // peripheral prescaler
   output var  pdm_pkg::pdm_state_t           power_mode_q     // current mode
);

   // ***************************************************************
   // register storage
   // ***************************************************************
   logic [7:0]                 sys_one_q;
   logic [7:0]                 sys_two_q;
   logic [7:0]                 halt_one_q;
   logic [7:0]                 halt_two_q;
   pdm_pkg::pdm_ctl_t          ctl;
   logic [2*8-1:0]             halt_all;

   // field decode of the two control registers
   assign ctl.sw_standby   = sys_one_q[pdm_pkg::SW_STANDBY_BIT];
   assign ctl.wait_sel     = sys_one_q[pdm_pkg::WAIT_SEL_HI:pdm_pkg::WAIT_SEL_LO];
   assign ctl.low_speed_on = sys_one_q[pdm_pkg::LOW_SPEED_BIT];
   assign ctl.watch_sel    = sys_one_q[pdm_pkg::WATCH_SEL_BIT];
   assign ctl.div_sel      = sys_two_q[pdm_pkg::DIV_SEL_HI:pdm_pkg::DIV_SEL_LO];
   assign ctl.med_speed_on = sys_two_q[pdm_pkg::MED_SPEED_BIT];
   assign ctl.sub_div_sel  = sys_two_q[pdm_pkg::SUB_DIV_HI:pdm_pkg::SUB_DIV_LO];
   assign halt_all         = {halt_two_q, halt_one_q};

   // ***************************************************************
   // clock sources
   // ***************************************************************
   logic       osc_div_tick;
   logic       sub_div_tick;
   logic       sys_tick;
   logic [1:0] sub_sel_clip;

   // codes above w/8 are held at w/8 so no undocumented ratio appears
   assign sub_sel_clip = (ctl.sub_div_sel > pdm_pkg::SUB_DIV_MAX) ?
                         pdm_pkg::SUB_DIV_MAX : ctl.sub_div_sel;

   pdm_tick_div #(
      .W    (pdm_pkg::DIV_W),
      .BASE (pdm_pkg::OSC_DIV_BASE)
   ) u_osc_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clr      (~osc_run_q),
      .tick_in  (osc_tick),
      .sel      (ctl.div_sel),
      .tick_out (osc_div_tick)
   );

   pdm_tick_div #(
      .W    (pdm_pkg::DIV_W),
      .BASE (pdm_pkg::SUB_DIV_BASE)
   ) u_sub_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clr      (1'b0),
      .tick_in  (sub_tick),
      .sel      (sub_sel_clip),
      .tick_out (sub_div_tick)
   );

   // system clock: full oscillator rate or the medium-speed divider
   assign sys_tick = osc_run_q & (ctl.med_speed_on ? osc_div_tick : osc_tick);

   // ***************************************************************
   // mode state machine
   // ***************************************************************
   pdm_pkg::pdm_state_t   state_d;
   logic [pdm_pkg::WAIT_W-1:0] wait_q;
   logic [pdm_pkg::WAIT_W-1:0] wait_term;
   logic                  wait_done;
   logic [3:0]            wait_shamt;

   // wait length 2**(base+sel) oscillator ticks (osc_tick, undivided)
   assign wait_shamt = 4'(pdm_pkg::WAIT_BASE_LOG) + {1'b0, ctl.wait_sel};
   assign wait_term  = ~({pdm_pkg::WAIT_W{1'b1}} << wait_shamt);
   assign wait_done  = osc_tick & (wait_q == wait_term);

   // transitions; sleep only taken from the two running modes
   always_comb
   begin
      state_d = power_mode_q;
      unique case (power_mode_q)
         pdm_pkg::ST_ACTIVE:
            if (sleep_req)
               state_d = !ctl.sw_standby ? pdm_pkg::ST_SLEEP :
                         (ctl.watch_sel ? pdm_pkg::ST_WATCH : pdm_pkg::ST_STANDBY);
         pdm_pkg::ST_SUBACT:
            if (sleep_req)
               state_d = !ctl.sw_standby ? pdm_pkg::ST_SUBSLEEP :
                         (ctl.watch_sel ? pdm_pkg::ST_WATCH : pdm_pkg::ST_STANDBY);
         pdm_pkg::ST_SLEEP:
            if (wake_irq) state_d = pdm_pkg::ST_ACTIVE;
         pdm_pkg::ST_SUBSLEEP:
            if (wake_irq) state_d = pdm_pkg::ST_SUBACT;
         pdm_pkg::ST_WATCH:
            if (wake_irq)
               state_d = ctl.low_speed_on ? pdm_pkg::ST_SUBACT : pdm_pkg::ST_OSC_START;
         pdm_pkg::ST_STANDBY:
            if (wake_irq) state_d = pdm_pkg::ST_OSC_START;
         pdm_pkg::ST_OSC_START:
            if (osc_started) state_d = pdm_pkg::ST_OSC_WAIT;
         pdm_pkg::ST_OSC_WAIT:
            if (wait_done) state_d = pdm_pkg::ST_ACTIVE;
         default:
            state_d = pdm_pkg::ST_ACTIVE;
      endcase
   end

   // oscillator runs in every mode whose next step needs the system clock
   logic osc_run_d;
   assign osc_run_d = (state_d == pdm_pkg::ST_ACTIVE)    ||
                      (state_d == pdm_pkg::ST_SLEEP)     ||
                      (state_d == pdm_pkg::ST_OSC_START) ||
                      (state_d == pdm_pkg::ST_OSC_WAIT);

   // mode register and oscillator control, six modes plus two wake steps
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         power_mode_q <= pdm_pkg::ST_ACTIVE;
         osc_run_q    <= 1'b1;
      end
      else
      begin
         power_mode_q <= state_d;
         osc_run_q    <= osc_run_d;
      end
   end

   // wait counter only runs once the system clock is being generated
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         wait_q <= '0;
      else if (power_mode_q != pdm_pkg::ST_OSC_WAIT)
         wait_q <= '0;
      else if (osc_tick)
         wait_q <= wait_q + pdm_pkg::WAIT_W'(1);
   end

   // ***************************************************************
   // clock enables and prescaler
   // ***************************************************************
   logic cpu_tick;
   logic per_tick;
   logic presc_clr;

   // enables are chosen whole ticks, so a switch can never cut a pulse short
   always_comb
   begin
      cpu_tick = 1'b0;
      per_tick = 1'b0;
      unique case (power_mode_q)
         pdm_pkg::ST_ACTIVE:
         begin
            cpu_tick = sys_tick;
            per_tick = sys_tick;
         end
         pdm_pkg::ST_SLEEP:    per_tick = sys_tick;
         pdm_pkg::ST_SUBACT:
         begin
            cpu_tick = sub_div_tick;
            per_tick = sub_div_tick;
         end
         pdm_pkg::ST_SUBSLEEP: per_tick = sub_div_tick;
         pdm_pkg::ST_WATCH:    per_tick = sub_tick;
         default:
         begin
            cpu_tick = 1'b0;
            per_tick = 1'b0;
         end
      endcase
   end

   // prescaler is dead whenever the system clock generator is stopped
   assign presc_clr = (power_mode_q == pdm_pkg::ST_STANDBY)  ||
                      (power_mode_q == pdm_pkg::ST_WATCH)    ||
                      (power_mode_q == pdm_pkg::ST_SUBACT)   ||
                      (power_mode_q == pdm_pkg::ST_SUBSLEEP) ||
                      (power_mode_q == pdm_pkg::ST_OSC_START);

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)         prescaler_q <= '0;
      else if (presc_clr) prescaler_q <= '0;
      else if (sys_tick)  prescaler_q <= prescaler_q + pdm_pkg::PRESC_W'(1);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n) cpu_clk_en_q <= 1'b0;
      else        cpu_clk_en_q <= cpu_tick;
   end

   // one gate per module; a zero halt bit keeps that module frozen
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MOD; gi++)
      begin : g_mod
         always_ff @(posedge core_clk)
         begin
            if (!rst_n) periph_clk_en_q[gi] <= 1'b0;
            else        periph_clk_en_q[gi] <= per_tick & halt_all[gi % 16];
         end
      end
   endgenerate

   // ***************************************************************
   // AXI4-Lite slave
   // ***************************************************************
   logic                      aw_held_q;
   logic                      w_held_q;
   logic [pdm_pkg::AXI_AW-1:0] awaddr_q;
   logic [7:0]                wbyte_q;
   logic                      wlane_q;
   logic                      do_write;
   logic                      wr_hit;
   logic                      rd_hit;
   logic [31:0]               rd_word;
   logic [2:0]                wait_ctl_hi;

   assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign wr_hit   = (awaddr_q == pdm_pkg::REG_SYS_ONE)  || (awaddr_q == pdm_pkg::REG_SYS_TWO) ||
                     (awaddr_q == pdm_pkg::REG_HALT_ONE) || (awaddr_q == pdm_pkg::REG_HALT_TWO) ||
                     (awaddr_q == pdm_pkg::REG_STATUS);
   assign rd_hit   = (s_axi_araddr == pdm_pkg::REG_SYS_ONE)  ||
                     (s_axi_araddr == pdm_pkg::REG_SYS_TWO)  ||
                     (s_axi_araddr == pdm_pkg::REG_HALT_ONE) ||
                     (s_axi_araddr == pdm_pkg::REG_HALT_TWO) ||
                     (s_axi_araddr == pdm_pkg::REG_STATUS);
   assign wait_ctl_hi = {osc_run_q, (power_mode_q == pdm_pkg::ST_OSC_WAIT),
                         (power_mode_q == pdm_pkg::ST_OSC_START)};

   // read mux; status shows the mode, oscillator and wake progress
   assign rd_word =
      (s_axi_araddr == pdm_pkg::REG_SYS_ONE)  ? {24'h000000, sys_one_q}  :
      (s_axi_araddr == pdm_pkg::REG_SYS_TWO)  ? {24'h000000, sys_two_q}  :
      (s_axi_araddr == pdm_pkg::REG_HALT_ONE) ? {24'h000000, halt_one_q} :
      (s_axi_araddr == pdm_pkg::REG_HALT_TWO) ? {24'h000000, halt_two_q} :
      (s_axi_araddr == pdm_pkg::REG_STATUS)   ?
         {prescaler_q, 12'h000, wait_ctl_hi, power_mode_q} : 32'h00000000;

   // write channels are taken in either order; one write at a time
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         awaddr_q      <= '0;
         wbyte_q       <= 8'h00;
         wlane_q       <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= pdm_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q     <= 1'b1;
            wbyte_q      <= s_axi_wdata[7:0];
            wlane_q      <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // register writes need byte lane 0; status writes are ignored
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         sys_one_q  <= pdm_pkg::SYS_ONE_RST;
         sys_two_q  <= pdm_pkg::SYS_TWO_RST;
         halt_one_q <= pdm_pkg::HALT_RST;
         halt_two_q <= pdm_pkg::HALT_RST;
      end
      else if (do_write && wlane_q)
      begin
         if (awaddr_q == pdm_pkg::REG_SYS_ONE)  sys_one_q  <= wbyte_q;
         if (awaddr_q == pdm_pkg::REG_SYS_TWO)  sys_two_q  <= wbyte_q;
         if (awaddr_q == pdm_pkg::REG_HALT_ONE) halt_one_q <= wbyte_q;
         if (awaddr_q == pdm_pkg::REG_HALT_TWO) halt_two_q <= wbyte_q;
      end
   end

   // read answers one cycle after the address is taken
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= pdm_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_hit ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // pdm_ctrl
`default_nettype wire

// File: rtl/pdm_pkg.sv
// package of constants and types for the power-down mode controller
package pdm_pkg;

   // ***************************************************************
   // register map (byte addresses, one aligned word each)
   // ***************************************************************
   localparam int          AXI_AW        = 5;
   localparam logic [4:0]  REG_SYS_ONE   = 5'h00;
   localparam logic [4:0]  REG_SYS_TWO   = 5'h04;
   localparam logic [4:0]  REG_HALT_ONE  = 5'h08;
   localparam logic [4:0]  REG_HALT_TWO  = 5'h0c;
   localparam logic [4:0]  REG_STATUS    = 5'h10;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int SW_STANDBY_BIT  = 7;   // system_control_one
   localparam int WAIT_SEL_HI     = 6;
   localparam int WAIT_SEL_LO     = 4;
   localparam int LOW_SPEED_BIT   = 3;
   localparam int WATCH_SEL_BIT   = 2;
   localparam int DIV_SEL_HI      = 1;   // system_control_two
   localparam int DIV_SEL_LO      = 0;
   localparam int MED_SPEED_BIT   = 2;
   localparam int SUB_DIV_HI      = 4;
   localparam int SUB_DIV_LO      = 3;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0]  SYS_ONE_RST   = 8'h00;
   localparam logic [7:0]  SYS_TWO_RST   = 8'h03;
   localparam logic [7:0]  HALT_RST      = 8'hff;

   // ***************************************************************
   // dividers, prescaler and wait counter
   // ***************************************************************
   localparam int          DIV_W         = 7;
   localparam int          OSC_DIV_BASE  = 3;   // code 00 -> osc/8
   localparam int          SUB_DIV_BASE  = 1;   // code 00 -> w/2
   localparam int          PRESC_W       = 13;
   localparam int          WAIT_W        = 12;
   localparam int          WAIT_BASE_LOG = 4;   // code 0 -> 16 states
   localparam logic [1:0]  SUB_DIV_MAX   = 2'h2; // w/8 is the slowest
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [3:0] {
      ST_ACTIVE    = 4'h0,
      ST_SLEEP     = 4'h1,
      ST_STANDBY   = 4'h3,
      ST_OSC_START = 4'h2,
      ST_OSC_WAIT  = 4'h6,
      ST_WATCH     = 4'h7,
      ST_SUBACT    = 4'h5,
      ST_SUBSLEEP  = 4'h4
   } pdm_state_t;

   typedef struct packed {
      logic       sw_standby;
      logic [2:0] wait_sel;
      logic       low_speed_on;
      logic       watch_sel;
      logic [1:0] div_sel;
      logic       med_speed_on;
      logic [1:0] sub_div_sel;
   } pdm_ctl_t;

endpackage : pdm_pkg

// File: rtl/pdm_tick_div.sv
// tick divider: passes one input tick in every 2**(base+sel)
`timescale 1ns/1ps
`default_nettype none
module pdm_tick_div #(
   parameter int W    = 7,
   parameter int BASE = 3
) (
   input  wire logic       core_clk,  // core clock
   input  wire logic       rst_n,     // synchronous reset, active low
   input  wire logic       clr,       // hold the count at zero
   input  wire logic       tick_in,   // source tick
   input  wire logic [1:0] sel,       // ratio code
   output var  logic       tick_out   // divided tick, one cycle
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic [W-1:0] mask;
   logic [3:0]   shamt;

   // mask of the low bits that must all be ones at the terminal tick
   assign shamt    = 4'(BASE) + {2'h0, sel};
   assign mask     = ~({W{1'b1}} << shamt);
   assign tick_out = tick_in & ((cnt_q & mask) == mask);
   assign cnt_d    = clr ? '0 : (tick_in ? cnt_q + W'(1) : cnt_q);

   // free count; output is a whole source tick, never a sliver of one
   always_ff @(posedge core_clk)
   begin
      if (!rst_n) cnt_q <= '0;
      else        cnt_q <= cnt_d;
   end

endmodule // pdm_tick_div
`default_nettype wire

// File: sim/pdm_ctrl_bench.sv
// self-checking bench for the power-down mode controller
`timescale 1ns/1ps
`default_nettype none
module pdm_ctrl_bench;
   // ***************************
   // stimulus, dut and checking
   // ***************************
   logic core_clk = 0, rst_n = 0, osc_tick = 0, sub_tick = 0, osc_started = 0, sleep_req = 0;
   logic wake_irq = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic awr, wrd, bv, arr, rv, cpu, osr;
   logic [4:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat;
   logic [1:0] br, rr;
   logic [15:0] per;
   logic [12:0] pre;
   pdm_pkg::pdm_state_t mode;
   int num_errors = 0, comparisons = 0, cyc = 0;
   initial forever #2 core_clk = ~core_clk;
   // system tick every 2 cycles, subclock tick every 8; hang guard well past the run length
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      osc_tick <= ~osc_tick;
      sub_tick <= cyc[2:0] == 3'h0;
      if (cyc == 10000)
      begin
         num_errors++;
         end_sim();
      end
   end
   pdm_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .osc_tick(osc_tick), .sub_tick(sub_tick),
      .osc_started(osc_started), .sleep_req(sleep_req), .wake_irq(wake_irq), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
      .cpu_clk_en_q(cpu), .periph_clk_en_q(per), .osc_run_q(osr), .prescaler_q(pre),
      .power_mode_q(mode));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // address and data are offered together; both readies rise together when idle
   task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge core_clk);
         if (awr) awv <= 1'h0;
         if (wrd) wv <= 1'h0;
      end
      while (awv && !awr || wv && !wrd);
      do @(posedge core_clk); while (!bv);
      r = br;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      ara <= a;
      arv <= 1'h1;
      rready <= 1'h1;
      do @(posedge core_clk); while (!arr);
      arv <= 1'h0;
      do @(posedge core_clk); while (!rv);
      d = rdat;
      r = rr;
   endtask
   // counts cpu, module 0 and module 8 enable pulses over n cycles
   task automatic cnt(input int n, output int c, output int p0, output int p8);
      c = 0;
      p0 = 0;
      p8 = 0;
      repeat (n)
      begin
         @(posedge core_clk);
         c += cpu;
         p0 += per[0];
         p8 += per[8];
      end
   endtask
   task automatic go(input logic w);
      if (w) wake_irq <= 1'h1;
      else sleep_req <= 1'h1;
      @(posedge core_clk);
      wake_irq <= 1'h0;
      sleep_req <= 1'h0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rd(pdm_pkg::REG_SYS_TWO, d, r);
      chk(d, 32'h3);
      rd(pdm_pkg::REG_HALT_TWO, d, r);
      chk(d, 32'hff);
      wr(pdm_pkg::REG_SYS_ONE, 32'h50, r);
      rd(pdm_pkg::REG_SYS_ONE, d, r);
      chk(d, 32'h50);
      wr(5'h14, 32'h1, r);
      chk(32'(r), 32'(pdm_pkg::RESP_SLVERR));
      rd(5'h14, d, r);
      chk(32'(r), 32'(pdm_pkg::RESP_SLVERR));
   endtask
   task automatic t_sleep;
      int c, p0, p8;
      logic [1:0] r;
      wr(pdm_pkg::REG_SYS_ONE, 32'h0, r);
      wr(pdm_pkg::REG_HALT_ONE, 32'h0, r);
      go(1'h0);
      chk(32'(mode), 32'(pdm_pkg::ST_SLEEP));
      cnt(64, c, p0, p8);
      chk(32'(c), 32'h0);
      chk(32'(p0), 32'h0);
      chk(32'(p8), 32'h20);
      go(1'h1);
      chk(32'(mode), 32'(pdm_pkg::ST_ACTIVE));
      wr(pdm_pkg::REG_HALT_ONE, 32'hff, r);
   endtask
   task automatic t_med;
      int c, p0, p8;
      logic [1:0] r;
      for (int k = 0; k < 4; k++)
      begin
         wr(pdm_pkg::REG_SYS_TWO, 32'(4 + k), r);
         cnt(16, c, p0, p8);
         cnt(512, c, p0, p8);
         chk(32'(c), 32'(32 >> k));
         chk(32'(p8), 32'(32 >> k));
      end
      wr(pdm_pkg::REG_SYS_TWO, 32'h3, r);
   endtask
   task automatic t_stby;
      logic [1:0] r;
      wr(pdm_pkg::REG_SYS_ONE, 32'h80, r);
      go(1'h0);
      chk(32'(mode), 32'(pdm_pkg::ST_STANDBY));
      chk(32'(pre), 32'h0);
      go(1'h1);
      chk(32'(mode), 32'(pdm_pkg::ST_OSC_START));
      chk(32'(osr), 32'h1);
      osc_started <= 1'h1;
      repeat (27) @(posedge core_clk);
      chk(32'(mode), 32'(pdm_pkg::ST_OSC_WAIT));
      repeat (14) @(posedge core_clk);
      chk(32'(mode), 32'(pdm_pkg::ST_ACTIVE));
      osc_started <= 1'h0;
   endtask
   task automatic t_watch;
      int c, p0, p8;
      logic [1:0] r;
      wr(pdm_pkg::REG_SYS_ONE, 32'h8c, r);
      go(1'h0);
      chk(32'(mode), 32'(pdm_pkg::ST_WATCH));
      go(1'h1);
      chk(32'(mode), 32'(pdm_pkg::ST_SUBACT));
      cnt(256, c, p0, p8);
      chk(32'(c), 32'h10);
      chk(32'(pre), 32'h0);
      wr(pdm_pkg::REG_SYS_ONE, 32'h8, r);
      go(1'h0);
      chk(32'(mode), 32'(pdm_pkg::ST_SUBSLEEP));
      cnt(256, c, p0, p8);
      chk(32'(p8), 32'h10);
   endtask
   task automatic end_sim;
      if (num_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // reset for ten cycles, then the scenarios in turn
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'h1;
      @(posedge core_clk);
      t_regs();
      t_sleep();
      t_med();
      t_stby();
      t_watch();
      end_sim();
   end
endmodule // pdm_ctrl_bench
`default_nettype wire

// File: sim/pdm_ctrl_props.sv
// checker for mode sequencing and clock enables of the power-down controller
`timescale 1ns/1ps
`default_nettype none
module pdm_ctrl_props #(
   parameter int NUM_MOD = 16
) (
   input  wire logic                        core_clk,        // core clock
   input  wire logic                        rst_n,           // sync reset, active low
   input  wire logic                        sleep_req,       // sleep instruction
   input  wire logic                        wake_irq,        // interrupt level
   input  wire logic                        osc_started,     // oscillator started
   input  wire logic                        cpu_clk_en_q,    // cpu enable
   input  wire logic [NUM_MOD-1:0]          periph_clk_en_q, // module enables
   input  wire logic                        osc_run_q,       // oscillator on
   input  wire logic [pdm_pkg::PRESC_W-1:0] prescaler_q,     // prescaler count
   input  wire pdm_pkg::pdm_state_t         power_mode_q     // current mode
);
   // ******
   // checks
   // ******
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // mode decodes; enables lag the mode by one cycle, so the halt and standby checks wait two
   wire logic st_sb    = power_mode_q == pdm_pkg::ST_STANDBY;
   wire logic st_start = power_mode_q == pdm_pkg::ST_OSC_START;
   wire logic st_wait  = power_mode_q == pdm_pkg::ST_OSC_WAIT;
   wire logic cpu_off  = power_mode_q inside {pdm_pkg::ST_SLEEP, pdm_pkg::ST_SUBSLEEP,
                                              pdm_pkg::ST_WATCH};
   sequence s_wake_sb;
      st_sb && wake_irq;
   endsequence
   a_halt_cpu_off: assert property (cpu_off [*2] |-> !cpu_clk_en_q)
      else $error("cpu enable pulsed in a halted mode");
   a_standby_all_off: assert property (st_sb [*2] |->
      !cpu_clk_en_q && periph_clk_en_q == '0)
      else $error("enable pulsed in standby");
   a_presc_cleared: assert property (st_sb [*2] |-> prescaler_q == '0)
      else $error("prescaler not cleared in standby");
   a_wake_restart: assert property (s_wake_sb |=> st_start && osc_run_q)
      else $error("wake did not restart oscillator");
   a_start_hold: assert property (st_start && !osc_started |=> st_start)
      else $error("left start before oscillator ready");
   a_start_done: assert property (st_start && osc_started |=> st_wait)
      else $error("no stabilisation wait after start");
   a_wait_idle: assert property (st_wait |-> !cpu_clk_en_q && periph_clk_en_q == '0)
      else $error("enable pulsed during wait");
   a_wait_min: assert property ($rose(st_wait) |-> st_wait [*8])
      else $error("wait ended too early");
   a_sleep_entry: assert property (power_mode_q == pdm_pkg::ST_ACTIVE && sleep_req |=>
      power_mode_q inside {pdm_pkg::ST_SLEEP, pdm_pkg::ST_STANDBY, pdm_pkg::ST_WATCH})
      else $error("sleep request went to wrong mode");
endmodule // pdm_ctrl_props
bind pdm_ctrl pdm_ctrl_props #(.NUM_MOD(NUM_MOD)) u_props (
   .core_clk(core_clk), .rst_n(rst_n), .sleep_req(sleep_req), .wake_irq(wake_irq),
   .osc_started(osc_started), .cpu_clk_en_q(cpu_clk_en_q), .periph_clk_en_q(periph_clk_en_q),
   .osc_run_q(osc_run_q), .prescaler_q(prescaler_q), .power_mode_q(power_mode_q));
`default_nettype wire
